// *** hw/htsif_pkg.sv ***
// Shared constants and types for the serial sensor interface.
package htsif_pkg;

	// System clock rate in kHz, so whole milliseconds convert exactly.
	localparam int CLK_KHZ = 25000;

	// Times in milliseconds, each at its printed figure.
	localparam int BOOT_MS = 11;
	localparam int MEAS8_MS = 20;
	localparam int MEAS12_MS = 80;
	localparam int MEAS14_MS = 320;
	localparam int RELOAD_MS = 10;

	// The same times as counts of system clock cycles.
	localparam int BOOT_CYC = BOOT_MS * CLK_KHZ;
	localparam int MEAS8_CYC = MEAS8_MS * CLK_KHZ;
	localparam int MEAS12_CYC = MEAS12_MS * CLK_KHZ;
	localparam int MEAS14_CYC = MEAS14_MS * CLK_KHZ;
	localparam int RELOAD_CYC = RELOAD_MS * CLK_KHZ;

	// Width of the shared wait timer, enough for the longest measurement.
	localparam int TMR_W = 24;

	// Clock rises with the data line high that reset the serial interface.
	localparam logic [3:0] CONN_RST_RISES = 4'h9;

	// Bit slot of a byte that carries the acknowledge.
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// Bytes sent for a measurement and for a status read, checksum included.
	localparam logic [1:0] BYTES_MEAS = 2'h3;
	localparam logic [1:0] BYTES_CFG = 2'h2;

	// Address field and command codes.
	localparam logic [2:0] CMD_ADDR = 3'h0;
	localparam logic [4:0] CMD_MEAS_TEMP = 5'h03;
	localparam logic [4:0] CMD_MEAS_HUMID = 5'h05;
	localparam logic [4:0] CMD_READ_CFG = 5'h07;
	localparam logic [4:0] CMD_WRITE_CFG = 5'h06;
	localparam logic [4:0] CMD_SOFT_RESET = 5'h1E;

	// Configuration reset value and the bits that a write may change.
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_WR_MASK = 8'h07;

	// Checksum generator polynomial and seed; the values are arbitrary.
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// Layout of the configuration/status register, bit 7 first.
	typedef struct packed {
		logic rsvd7;
		logic low_supply;
		logic [1:0] rsvd54;
		logic test3;
		logic heater;
		logic no_reload;
		logic low_res;
	} htsif_cfg_t;

	// Raw conversion results from the analog front end.
	typedef struct packed {
		logic [13:0] temp;
		logic [11:0] humid;
	} htsif_raw_t;

	// One checksum step over a single bit, most significant first.
	function automatic logic [7:0] htsif_crc_bit(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[7] ^ b;
		htsif_crc_bit = fb ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
	endfunction

	// Checksum step over a whole byte, most significant bit first.
	function automatic logic [7:0] htsif_crc_byte(input logic [7:0] c, input logic [7:0] v);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = htsif_crc_bit(r, v[i]);
		end
		htsif_crc_byte = r;
	endfunction

endpackage

// *** hw/htsif_top.sv ***
// Operation
// - Ignore the line for 11 ms after reset.
// - Zero address, five command bits, then acknowledge.
// - Codes 00011 and 00101 start measurements.
// - Code 00111 reads, 00110 writes configuration.
// - Code 11110 resets interface and configuration.
// - Measurement lasts 20, 80 or 320 ms.
// - Pull data low when result is ready.
// - Hold the result until read, no timeout.
// - Send two bytes, checksum, controller acknowledges each.
// - Results go MSB first, right justified.
// - End after checksum, or when acknowledge stays high.
// - Return to sleep after readout without command.
// - Nine high-data clock rises reset the interface.
// - Append an 8-bit checksum over the transfer.
// - Bit 0 selects reduced resolution.
// - Bit 1 skips calibration reload, saves 10 ms.
// - Bit 2 switches the heater on.
// - Bit 6 shows low supply after measurements.
// - Reserved bits 7, 5, 4, 3 stay zero.
// - Data changes only after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none

module htsif_top #(
	parameter int BOOT_CYCLES = htsif_pkg::BOOT_CYC,
	parameter int MEAS8_CYCLES = htsif_pkg::MEAS8_CYC,
	parameter int MEAS12_CYCLES = htsif_pkg::MEAS12_CYC,
	parameter int MEAS14_CYCLES = htsif_pkg::MEAS14_CYC,
	parameter int RELOAD_CYCLES = htsif_pkg::RELOAD_CYC
) (
	// Clock, reset and clock enable.
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// Serial pins; the data pin is open drain.
	input wire logic SCK,
	input wire logic DATA_I,
	output logic DATA_O,
	output logic DATA_OE,
	// Analog front end.
	input wire htsif_pkg::htsif_raw_t RAW,
	input wire logic LOW_SUPPLY,
	// Status toward the rest of the chip.
	output logic MEAS_ACTIVE,
	output logic MEAS_HUMID,
	output logic OTP_RELOAD,
	output logic HEATER_EN,
	output logic SLEEP,
	output htsif_pkg::htsif_cfg_t CFG
);
	import htsif_pkg::*;

	// Interface states.
	typedef enum logic [3:0] {
		ST_BOOT, ST_IDLE, ST_START, ST_CMD, ST_CACK, ST_WRX, ST_WACK, ST_MEAS, ST_SEND
	} htsif_state_t;

	// Two-flop synchronisers for the pins; the first stage feeds only the second.
	logic sck_m_q, sck_s_q, sck_p_q;
	logic dat_m_q, dat_s_q, dat_p_q;
	logic low_m_q, low_s_q;

	// Edges found on the synchronised pins.
	logic sck_rise, sck_fall, dat_rise, dat_fall;

	// Protocol state and its next values.
	htsif_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] byte_q, byte_d;
	logic [1:0] nbytes_q, nbytes_d;
	logic [7:0] shift_q, shift_d;
	logic [23:0] tx_q, tx_d;
	logic [7:0] crc_q, crc_d;
	htsif_cfg_t cfg_q, cfg_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic hum_q, hum_d;
	logic ack_q, ack_d;
	logic [3:0] hi_q, hi_d;
	logic reload_q, reload_d;
	logic oe_q, oe_d;

	// Helpers for command decode and result formatting.
	logic cmd_ok;
	logic [15:0] word;
	logic [TMR_W-1:0] meas_len;

	// Synchronisers run off the clock enable like all other state.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			dat_m_q <= 1'b1;
			dat_s_q <= 1'b1;
			dat_p_q <= 1'b1;
			low_m_q <= 1'b0;
			low_s_q <= 1'b0;
		end else if (CE) begin
			sck_m_q <= SCK;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			dat_m_q <= DATA_I;
			dat_s_q <= dat_m_q;
			dat_p_q <= dat_s_q;
			low_m_q <= LOW_SUPPLY;
			low_s_q <= low_m_q;
		end
	end

	// Edges are taken from the second stage against its delayed copy.
	assign sck_rise = sck_s_q & ~sck_p_q;
	assign sck_fall = ~sck_s_q & sck_p_q;
	assign dat_rise = dat_s_q & ~dat_p_q;
	assign dat_fall = ~dat_s_q & dat_p_q;

	// Only address zero with a known code is taken.
	always_comb begin
		cmd_ok = 1'b0;
		if (shift_q[7:5] == CMD_ADDR) begin
			case (shift_q[4:0])
				CMD_MEAS_TEMP, CMD_MEAS_HUMID, CMD_READ_CFG, CMD_WRITE_CFG, CMD_SOFT_RESET: cmd_ok = 1'b1;
				default: cmd_ok = 1'b0;
			endcase
		end
	end

	// Right-justified result; the top bit is always zero, which doubles as ready.
	always_comb begin
		if (hum_q) begin
			word = cfg_q.low_res ? {8'h00, RAW.humid[11:4]} : {4'h0, RAW.humid};
		end else begin
			word = cfg_q.low_res ? {4'h0, RAW.temp[13:2]} : {2'b00, RAW.temp};
		end
	end

	// Conversion time from the resolution, shortened when reload is skipped.
	always_comb begin
		if (hum_d) begin
			meas_len = cfg_q.low_res ? TMR_W'(MEAS8_CYCLES) : TMR_W'(MEAS12_CYCLES);
		end else begin
			meas_len = cfg_q.low_res ? TMR_W'(MEAS12_CYCLES) : TMR_W'(MEAS14_CYCLES);
		end
		if (cfg_q.no_reload) begin
			meas_len = meas_len - TMR_W'(RELOAD_CYCLES);
		end
	end

	// Next-state logic of the serial protocol.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		byte_d = byte_q;
		nbytes_d = nbytes_q;
		shift_d = shift_q;
		tx_d = tx_q;
		crc_d = crc_q;
		cfg_d = cfg_q;
		tmr_d = tmr_q;
		hum_d = hum_q;
		ack_d = ack_q;
		hi_d = hi_q;
		reload_d = 1'b0;
		// Count clock rises seen with the line high; any low rise restarts it.
		if (sck_rise) begin
			hi_d = dat_s_q ? ((hi_q == CONN_RST_RISES) ? hi_q : hi_q + 4'h1) : 4'h0;
		end
		case (st_q)
			ST_BOOT: begin
				// Deaf until the power-up or soft-reset wait has run out.
				if (tmr_q == '0) begin
					st_d = ST_IDLE;
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			ST_IDLE: begin
				// Asleep; only a start sequence wakes the interface.
			end
			ST_START: begin
				// Data rising with the clock high completes the start.
				if (dat_rise && sck_s_q) begin
					st_d = ST_CMD;
					cnt_d = 4'h0;
					crc_d = CRC_INIT;
				end
			end
			ST_CMD: begin
				// Command bits are taken on rising edges.
				if (sck_rise) begin
					shift_d = {shift_q[6:0], dat_s_q};
					crc_d = htsif_crc_bit(crc_q, dat_s_q);
					cnt_d = cnt_q + 4'h1;
				end else if (sck_fall && cnt_q == ACK_SLOT) begin
					// Acknowledge after the 8th fall, or drop an unknown command.
					st_d = cmd_ok ? ST_CACK : ST_IDLE;
				end
			end
			ST_CACK: begin
				// The 9th fall ends the acknowledge and starts the command.
				if (sck_fall) begin
					cnt_d = 4'h0;
					byte_d = 2'h0;
					case (shift_q[4:0])
						CMD_MEAS_TEMP, CMD_MEAS_HUMID: begin
							st_d = ST_MEAS;
							hum_d = (shift_q[4:0] == CMD_MEAS_HUMID);
							tmr_d = meas_len;
							reload_d = ~cfg_q.no_reload;
						end
						CMD_READ_CFG: begin
							st_d = ST_SEND;
							nbytes_d = BYTES_CFG;
							tx_d = {cfg_q, htsif_crc_byte(crc_q, cfg_q), 8'h00};
						end
						CMD_WRITE_CFG: begin
							st_d = ST_WRX;
						end
						default: begin
							// Soft reset keeps only the supply flag, which has no default.
							st_d = ST_BOOT;
							cfg_d = CFG_RESET;
							cfg_d.low_supply = cfg_q.low_supply;
							tmr_d = TMR_W'(BOOT_CYCLES);
						end
					endcase
				end
			end
			ST_WRX: begin
				// New register value, taken on rising edges.
				if (sck_rise) begin
					shift_d = {shift_q[6:0], dat_s_q};
					cnt_d = cnt_q + 4'h1;
				end else if (sck_fall && cnt_q == ACK_SLOT) begin
					st_d = ST_WACK;
				end
			end
			ST_WACK: begin
				// Reserved and read-only bits are not written.
				if (sck_fall) begin
					st_d = ST_IDLE;
					cfg_d = (cfg_q & ~CFG_WR_MASK) | (shift_q & CFG_WR_MASK);
				end
			end
			ST_MEAS: begin
				// The clock is ignored while converting.
				if (tmr_q == '0) begin
					st_d = ST_SEND;
					nbytes_d = BYTES_MEAS;
					tx_d = {word, htsif_crc_byte(htsif_crc_byte(crc_q, word[15:8]), word[7:0])};
					cfg_d.low_supply = low_s_q;
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			ST_SEND: begin
				// No timeout here: the result waits for the controller.
				if (sck_rise && cnt_q == ACK_SLOT) begin
					ack_d = dat_s_q;
				end else if (sck_fall) begin
					if (cnt_q != ACK_SLOT) begin
						tx_d = {tx_q[22:0], 1'b0};
						cnt_d = cnt_q + 4'h1;
					end else if (!ack_q && (byte_q + 2'h1) != nbytes_q) begin
						byte_d = byte_q + 2'h1;
						cnt_d = 4'h0;
					end else begin
						st_d = ST_IDLE;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		// Line resets and starts act everywhere except while booting or converting.
		if (st_q != ST_BOOT && st_q != ST_MEAS) begin
			if (sck_rise && dat_s_q && hi_q == CONN_RST_RISES - 4'h1) begin
				st_d = ST_IDLE;
			end
			if (dat_fall && sck_s_q) begin
				st_d = ST_START;
			end
		end
	end

	// The pin is pulled low for acknowledges and zero bits, released otherwise.
	always_comb begin
		case (st_d)
			ST_CACK, ST_WACK: oe_d = 1'b1;
			ST_SEND: oe_d = (cnt_d != ACK_SLOT) && !tx_d[23];
			default: oe_d = 1'b0;
		endcase
	end

	// Registers of the protocol; the wait timer starts with the power-up wait.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= ST_BOOT;
			cnt_q <= 4'h0;
			byte_q <= 2'h0;
			nbytes_q <= 2'h0;
			shift_q <= 8'h00;
			tx_q <= 24'h000000;
			crc_q <= CRC_INIT;
			cfg_q <= CFG_RESET;
			tmr_q <= TMR_W'(BOOT_CYCLES);
			hum_q <= 1'b0;
			ack_q <= 1'b1;
			hi_q <= 4'h0;
			reload_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			byte_q <= byte_d;
			nbytes_q <= nbytes_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			crc_q <= crc_d;
			cfg_q <= cfg_d;
			tmr_q <= tmr_d;
			hum_q <= hum_d;
			ack_q <= ack_d;
			hi_q <= hi_d;
			reload_q <= reload_d;
			oe_q <= oe_d;
		end
	end

	// Open drain: the driven level is always low.
	assign DATA_O = 1'b0;
	assign DATA_OE = oe_q;

	// Status decoded from state registers.
	assign MEAS_ACTIVE = (st_q == ST_MEAS);
	assign MEAS_HUMID = hum_q;
	assign OTP_RELOAD = reload_q;
	assign HEATER_EN = cfg_q.heater;
	assign SLEEP = (st_q == ST_IDLE) || (st_q == ST_START);
	assign CFG = cfg_q;

endmodule

`default_nettype wire

// *** test/htsif_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// Pin-level watch over the sensor interface.
module htsif_checker #(
	parameter int MEAS14_CYCLES = htsif_pkg::MEAS14_CYC
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESETN,
	// Serial pins.
	input wire logic SCK,
	input wire logic DATA_O,
	input wire logic DATA_OE,
	// Status outputs.
	input wire logic MEAS_ACTIVE,
	input wire logic OTP_RELOAD,
	input wire logic HEATER_EN,
	input wire logic SLEEP,
	input wire htsif_pkg::htsif_cfg_t CFG
);
	import htsif_pkg::*;
	logic [23:0] len_q; // Cycles spent in the running conversion.
	logic [23:0] len_d;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// The count restarts whenever no conversion runs.
	always_comb begin
		len_d = MEAS_ACTIVE ? len_q + 24'h000001 : 24'h000000;
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			len_q <= 24'h000000;
		else
			len_q <= len_d;
	end
	drive_low_a: assert property (DATA_O == 1'b0) else $error("data driven high");
	heater_bit_a: assert property (HEATER_EN == CFG.heater) else $error("heater mismatch");
	rsvd_zero_a: assert property ({CFG.rsvd7, CFG.rsvd54, CFG.test3} == 4'h0)
		else $error("reserved bit set");
	meas_bound_a: assert property (MEAS_ACTIVE |-> len_q <= 24'(MEAS14_CYCLES))
		else $error("conversion overran");
	ready_low_a: assert property ($fell(MEAS_ACTIVE) |-> ##[0:2] DATA_OE)
		else $error("no ready after conversion");
	reload_pulse_a: assert property (OTP_RELOAD |-> !CFG.no_reload ##1 !OTP_RELOAD)
		else $error("bad reload pulse");
	supply_upd_a: assert property (!$stable(CFG.low_supply) |-> $past(MEAS_ACTIVE) || $past(MEAS_ACTIVE, 2))
		else $error("supply flag moved outside conversion");
	quiet_sleep_a: assert property (SLEEP |-> !DATA_OE && !MEAS_ACTIVE)
		else $error("busy while asleep");
	// Sync delay means a change lands several cycles after a low clock.
	fall_launch_a: assert property (!$stable(DATA_OE) |-> !$past(SCK, 2) && !$past(SCK, 3))
		else $error("data changed with clock high");
endmodule

bind htsif_top htsif_checker #(.MEAS14_CYCLES(MEAS14_CYCLES)) u_htsif_checker (.CLK(CLK), .RESETN(RESETN),
	.SCK(SCK), .DATA_O(DATA_O), .DATA_OE(DATA_OE), .MEAS_ACTIVE(MEAS_ACTIVE), .OTP_RELOAD(OTP_RELOAD),
	.HEATER_EN(HEATER_EN), .SLEEP(SLEEP), .CFG(CFG));
`default_nettype wire

// *** test/htsif_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
// Controller model: owns the link clock and only ever pulls data low.
module htsif_partner (
	// Clock and wired data level.
	input wire logic clk,
	input wire logic line,
	// Link pins.
	output logic sck,
	output logic pull,
	// Received byte or ack, with a one-cycle strobe.
	output logic got_v,
	output logic [7:0] got
);
	logic smp; // Line level just before the last clock fall.
	initial {sck, pull, got_v, got} = 11'h000;
	// Half a link period; the clock stands low between frames.
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	// Clock and data pairs of the opening sequence.
	task automatic start();
		logic [11:0] seq;
		seq = 12'hB78;
		for (int i = 10; i >= 0; i -= 2) begin
			half();
			{sck, pull} <= seq[i+:2];
		end
		half();
	endtask
	// One clock: data set after the fall, sampled just before the next fall.
	task automatic pulse(input logic d);
		pull <= ~d;
		half();
		sck <= 1'b1;
		half();
		smp = line;
		sck <= 1'b0;
	endtask
	// Hands a result over and releases data one cycle after the fall.
	task automatic post(input logic [7:0] v);
		@(posedge clk);
		got <= v;
		got_v <= 1'b1;
		pull <= 1'b0;
		@(posedge clk);
		got_v <= 1'b0;
	endtask
	// Sends a byte; reports 1 when the device acked.
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			pulse(b[i]);
		pulse(1'b1);
		post({7'h00, ~smp});
	endtask
	// Reads a byte; ack high pulls data low in the ninth clock.
	task automatic recv(input logic ack);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++) begin
			pulse(1'b1);
			v = {v[6:0], smp};
		end
		pulse(~ack);
		post(v);
	endtask
endmodule
`default_nettype wire

// *** test/htsif_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// Driver notes expected bytes; a monitor compares what the controller reads.
module htsif_top_tb;
	import htsif_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic low_sup = 1'b0;
	htsif_raw_t raw = '0;
	logic oe, sck, pull, got_v, sleep, humid, heater;
	logic ce = 1'b1; // Clock enable, dropped once during the power-up wait.
	logic dout, mact, reload; // Driven level, conversion flag and reload pulse.
	int reload_n = 0; // Reload pulses seen so far.
	logic [7:0] got;
	htsif_cfg_t cfg;
	logic [7:0] cfg_e = 8'h00; // Expected register content.
	logic [7:0] exp_q[$]; // Expected bytes and acks, oldest first.
	int fail_count = 0;
	int total_checks = 0;
	wire line = ~(oe | pull); // Open drain with a pull-up.
	initial forever #20 clk = ~clk;
	// Short counts keep the run brief; the boot check and the 4000-cycle wait bound rely on them.
	htsif_top #(.BOOT_CYCLES(50), .MEAS8_CYCLES(100), .MEAS12_CYCLES(200), .MEAS14_CYCLES(400),
		.RELOAD_CYCLES(20)) u_htsif_top (.CLK(clk), .RESETN(rstn), .CE(ce), .SCK(sck), .DATA_I(line),
		.DATA_O(dout), .DATA_OE(oe), .RAW(raw), .LOW_SUPPLY(low_sup), .MEAS_ACTIVE(mact), .MEAS_HUMID(humid),
		.OTP_RELOAD(reload), .HEATER_EN(heater), .SLEEP(sleep), .CFG(cfg));
	htsif_partner u_htsif_partner (.clk(clk), .line(line), .sck(sck), .pull(pull), .got_v(got_v), .got(got));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait for sleep (1) or a low data line (0).
	task automatic await(input logic s);
		for (int k = 0; k < 4000; k++) begin
			if (s ? sleep === 1'b1 : line === 1'b0)
				return;
			@(posedge clk);
		end
		fail_count++;
		tally_and_finish();
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic cmd(input logic [7:0] b, input logic a);
		u_htsif_partner.start();
		exp_q.push_back({7'h00, a});
		u_htsif_partner.send(b);
	endtask
	task automatic wr_cfg(input logic [7:0] v);
		cmd(8'h06, 1'b1);
		exp_q.push_back(8'h01);
		u_htsif_partner.send(v);
		// The write lands a few cycles after the pin edge, behind the synchronisers.
		repeat (4) @(posedge clk);
		cfg_e = (cfg_e & 8'h40) | (v & CFG_WR_MASK);
		chk("cfg", cfg_e, cfg);
		chk("heater", {7'h00, cfg_e[2]}, {7'h00, heater});
	endtask
	task automatic rd_cfg();
		cmd(8'h07, 1'b1);
		exp_q.push_back(cfg_e);
		u_htsif_partner.recv(1'b1);
		exp_q.push_back(crc8(crc8(CRC_INIT, 8'h07), cfg_e));
		u_htsif_partner.recv(1'b1);
		await(1'b1);
	endtask
	task automatic meas(input logic h, input logic skip);
		logic [15:0] w;
		int r0;
		raw <= 26'($urandom);
		@(posedge clk);
		w = h ? (cfg_e[0] ? {8'h00, raw.humid[11:4]} : {4'h0, raw.humid})
			: (cfg_e[0] ? {4'h0, raw.temp[13:2]} : {2'b00, raw.temp});
		r0 = reload_n;
		cmd(h ? 8'h05 : 8'h03, 1'b1);
		repeat (8) @(posedge clk);
		chk("humid", {7'h00, h}, {7'h00, humid});
		chk("active", 8'h01, {7'h00, mact});
		await(1'b0);
		// Ready must be the device pulling low, never driving high.
		chk("ready drive", 8'h02, {6'h00, oe, dout});
		chk("active end", 8'h00, {7'h00, mact});
		chk("reload", {7'h00, ~cfg_e[1]}, 8'(reload_n - r0));
		repeat (300) @(posedge clk);
		cfg_e[6] = low_sup;
		exp_q.push_back(w[15:8]);
		u_htsif_partner.recv(1'b1);
		exp_q.push_back(w[7:0]);
		u_htsif_partner.recv(!skip);
		if (!skip) begin
			exp_q.push_back(crc8(crc8(crc8(CRC_INIT, h ? 8'h05 : 8'h03), w[15:8]), w[7:0]));
			u_htsif_partner.recv(1'b1);
		end
		await(1'b1);
		chk("status", cfg_e, cfg);
	endtask
	// Each reported byte meets the oldest note.
	always @(posedge clk) begin
		// Reload pulses are counted so each measurement can be judged afterwards.
		if (reload === 1'b1)
			reload_n <= reload_n + 1;
		if (got_v === 1'b1) begin
			if (exp_q.size() == 0)
				chk("spare byte", 8'h00, 8'hFF);
			else
				chk("byte", exp_q.pop_front(), got);
		end
	end
	initial begin
		void'($urandom(32'h561DEF4E));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		ce <= 1'b0;
		chk("reset cfg", CFG_RESET, cfg);
		// A frozen block must not count down its power-up wait.
		repeat (100) @(posedge clk);
		chk("frozen boot", 8'h00, {7'h00, sleep});
		ce <= 1'b1;
		repeat (40) @(posedge clk);
		chk("boot", 8'h00, {7'h00, sleep});
		await(1'b1);
		// All resolution, reload and quantity pairs; the last skips the checksum.
		for (int i = 0; i < 4; i++) begin
			wr_cfg({5'h00, 1'($urandom), i[0], i[1]});
			low_sup <= i[0];
			meas(i[1] ^ i[0], i == 3);
			// Long quiet time after each conversion keeps the duty cycle low.
			repeat (9000) @(posedge clk);
			rd_cfg();
		end
		cmd(8'h23, 1'b0);
		await(1'b1);
		cmd(8'h01, 1'b0);
		await(1'b1);
		rd_cfg();
		u_htsif_partner.start();
		for (int i = 0; i < 13; i++)
			u_htsif_partner.pulse(i > 2);
		rd_cfg();
		cmd(8'h1E, 1'b1);
		cfg_e = cfg_e & 8'h40;
		repeat (8) @(posedge clk);
		await(1'b1);
		rd_cfg();
		chk("pending", 8'h00, 8'(exp_q.size()));
		tally_and_finish();
	end
endmodule
`default_nettype wire
